// File: common/pcfu_pkg.sv
// Shared constants and carrier types of the program counter fetch unit.
package pcfu_pkg;

    // ==========================================================
    // Widths and address space
    // ==========================================================
    localparam int unsigned PC_W       = 21;     // Byte address width.
    localparam int unsigned INSTR_W    = 16;     // One instruction word.
    localparam int unsigned PM_BYTES   = 16384;  // Implemented program memory.
    localparam int unsigned PM_WORDS   = 8192;   // Single-word instructions.
    localparam int unsigned PM_AW      = 13;     // Word index width.
    localparam int unsigned STK_DEPTH  = 32;     // Slot 0 is never written.
    localparam int unsigned STK_AW     = 5;
    localparam logic [STK_AW-1:0] STK_TOP = 5'h1f;
    localparam logic [PC_W-1:0]   PC_STEP = 21'h000002;

    // ==========================================================
    // Vectors and reset values
    // ==========================================================
    localparam logic [PC_W-1:0] RESET_VEC   = 21'h000000;
    localparam logic [PC_W-1:0] IRQ_HI_VEC  = 21'h000008;
    localparam logic [PC_W-1:0] IRQ_LO_VEC  = 21'h000018;
    localparam logic [7:0]      LATCH_RST   = 8'h00;
    localparam logic [STK_AW-1:0] SP_RST    = 5'h00;

    // ==========================================================
    // Register offsets on the 8-bit register port
    // ==========================================================
    localparam logic [2:0] OFS_PC_LOW     = 3'h0;
    localparam logic [2:0] OFS_HIGH_LATCH = 3'h1;
    localparam logic [2:0] OFS_UPPER_LATCH= 3'h2;
    localparam logic [2:0] OFS_TOS_LOW    = 3'h3;
    localparam logic [2:0] OFS_TOS_HIGH   = 3'h4;
    localparam logic [2:0] OFS_TOS_UPPER  = 3'h5;
    localparam logic [2:0] OFS_STACK_PTR  = 3'h6;
    localparam logic [2:0] OFS_IRQ_CTRL   = 3'h7;

    // Field positions.
    localparam int unsigned BIT_STK_FULL  = 7;   // In stack pointer reg.
    localparam int unsigned BIT_STK_UNDER = 6;
    localparam int unsigned BIT_GIE_LOW   = 0;   // In interrupt control reg.
    localparam int unsigned BIT_GIE_HIGH  = 1;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic            wr;       // Write strobe.
        logic            rd;       // Read strobe.
        logic [2:0]      addr;     // Register offset.
        logic [7:0]      wdata;    // Write data.
    } pcfu_reg_req_t;

    typedef struct packed {
        logic            adv;      // Step to the next instruction word.
        logic            branch;   // Direct load from the instruction.
        logic            call;     // With branch: push the return address.
        logic            ret;      // Pop the return address.
        logic [PC_W-1:0] target;   // Branch destination.
    } pcfu_core_cmd_t;

endpackage

// File: design/pcfu_mem.sv
// Simple dual-port memory with a registered read and a zero override.
`timescale 1ns/100ps

module pcfu_mem #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8192,
    parameter int unsigned AW    = 13
) (
    input  wire logic             clk_i,      // Core clock.
    input  wire logic             arst_n_i,   // Asynchronous reset, low.
    input  wire logic             we_i,       // Write enable.
    input  wire logic [AW-1:0]    waddr_i,    // Write index.
    input  wire logic [WIDTH-1:0] wdata_i,    // Write data.
    input  wire logic [AW-1:0]    raddr_i,    // Read index.
    input  wire logic             zero_i,     // Force the read data to zero.
    output logic      [WIDTH-1:0] rdata_o     // Read data, registered.
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    // Storage has no reset; the contents are loaded before use.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Read register; zero_i lets a caller blank holes in its space.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= zero_i ? '0 : mem_q[raddr_i];
        end
    end

endmodule // pcfu_mem

// File: design/pcfu_top.sv
// Program counter, fetch addressing, latches and return stack of the core.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps

module pcfu_top #(
    parameter int unsigned PM_SIZE = pcfu_pkg::PM_BYTES
) (
    input  wire logic                   clk_i,        // Core clock, 40 MHz.
    input  wire logic                   arst_n_i,     // Async reset, low.
    input  wire pcfu_pkg::pcfu_reg_req_t reg_req_i,   // Register port request.
    output logic [7:0]                  reg_rdata_o,  // Read data, next cycle.
    input  wire pcfu_pkg::pcfu_core_cmd_t core_cmd_i, // Decoder commands.
    input  wire logic                   irq_wake_i,   // Interrupt wake pulse.
    input  wire logic                   irq_high_i,   // High priority source.
    input  wire logic                   pm_we_i,      // Program load strobe.
    input  wire logic [pcfu_pkg::PM_AW-1:0] pm_waddr_i, // Program word index.
    input  wire logic [pcfu_pkg::INSTR_W-1:0] pm_wdata_i, // Program word.
    output logic [pcfu_pkg::PC_W-1:0]   fetch_addr_o, // Current fetch address.
    output logic [pcfu_pkg::INSTR_W-1:0] fetch_data_o, // Word, one cycle on.
    output logic [pcfu_pkg::STK_AW-1:0] sp_o          // Return stack pointer.
);

    localparam int unsigned PC_W = pcfu_pkg::PC_W;
    localparam int unsigned SAW  = pcfu_pkg::STK_AW;

    // ==========================================================
    // State
    // ==========================================================
    logic [PC_W-1:0] pc_q, pc_d;
    logic [7:0]      pc_high_latch_q, pc_high_latch_d;
    logic [4:0]      pc_upper_latch_q, pc_upper_latch_d;
    logic [SAW-1:0]  sp_q, sp_d;
    logic            stk_full_q, stk_full_d;
    logic            stk_under_q, stk_under_d;
    logic            gie_low_q, gie_high_q;
    logic [7:0]      rdata_d;
    logic [PC_W-1:0] stack_top_word;

    // ==========================================================
    // Request decode
    // ==========================================================
    wire wr_pc_low  = reg_req_i.wr && reg_req_i.addr == pcfu_pkg::OFS_PC_LOW;
    wire rd_pc_low  = reg_req_i.rd && reg_req_i.addr == pcfu_pkg::OFS_PC_LOW;
    wire wr_high    = reg_req_i.wr
                      && reg_req_i.addr == pcfu_pkg::OFS_HIGH_LATCH;
    wire wr_upper   = reg_req_i.wr
                      && reg_req_i.addr == pcfu_pkg::OFS_UPPER_LATCH;
    wire wr_sp      = reg_req_i.wr
                      && reg_req_i.addr == pcfu_pkg::OFS_STACK_PTR;
    wire wr_irqc    = reg_req_i.wr
                      && reg_req_i.addr == pcfu_pkg::OFS_IRQ_CTRL;

    // Priority: interrupt, software low-byte write, branch, return,
    // then the sequential step. Only one source changes the PC a cycle.
    wire take_irq   = irq_wake_i && (gie_low_q || gie_high_q);
    wire do_pcl_wr  = !take_irq && wr_pc_low;
    wire do_branch  = !take_irq && !wr_pc_low && core_cmd_i.branch;
    wire do_ret     = !take_irq && !wr_pc_low && !core_cmd_i.branch
                      && core_cmd_i.ret;
    wire do_adv     = !take_irq && !wr_pc_low && !core_cmd_i.branch
                      && !core_cmd_i.ret && core_cmd_i.adv;
    wire do_push    = take_irq || (do_branch && core_cmd_i.call);
    wire stk_is_top = sp_q == pcfu_pkg::STK_TOP;
    wire stk_is_0   = sp_q == pcfu_pkg::SP_RST;

    // High source takes the lower vector, low source the upper one.
    wire [PC_W-1:0] irq_vec = irq_high_i ? pcfu_pkg::IRQ_HI_VEC
                                         : pcfu_pkg::IRQ_LO_VEC;

    // The latches fill the upper bits; data bit 0 is dropped.
    wire [PC_W-1:0] pcl_wr_val = {pc_upper_latch_q, pc_high_latch_q,
                                  reg_req_i.wdata[7:1], 1'b0};

    // Holes above the implemented array are blanked, so they fetch NOPs.
    wire pm_hole = pc_q >= PC_W'(PM_SIZE);

    // ==========================================================
    // Next program counter
    // ==========================================================
    // Bit 0 is forced low on every path so no load can misalign it.
    always_comb begin
        pc_d = pc_q;
        if (take_irq) begin
            pc_d = irq_vec;
        end else if (do_pcl_wr) begin
            pc_d = pcl_wr_val;
        end else if (do_branch) begin
            pc_d = {core_cmd_i.target[PC_W-1:1], 1'b0};
        end else if (do_ret) begin
            pc_d = stk_is_0 ? pcfu_pkg::RESET_VEC : stack_top_word;
        end else if (do_adv) begin
            pc_d = pc_q + pcfu_pkg::PC_STEP;
        end
        pc_d[0] = 1'b0;
    end

    // ==========================================================
    // Latches
    // ==========================================================
    // Upper PC bytes are never written by software directly, only here.
    always_comb begin
        pc_high_latch_d  = pc_high_latch_q;
        pc_upper_latch_d = pc_upper_latch_q;
        if (rd_pc_low) begin
            pc_high_latch_d  = pc_q[15:8];
            pc_upper_latch_d = pc_q[20:16];
        end else if (wr_high) begin
            pc_high_latch_d  = reg_req_i.wdata;
        end else if (wr_upper) begin
            pc_upper_latch_d = reg_req_i.wdata[4:0];
        end
    end

    // ==========================================================
    // Stack pointer and sticky stack flags
    // ==========================================================
    // The pointer saturates at the top slot, so a push past it leaves
    // the last entry intact; a pop at zero sets the underflow flag.
    // A flag set by hardware wins over a software clear in one cycle.
    always_comb begin
        sp_d        = sp_q;
        stk_full_d  = stk_full_q;
        stk_under_d = stk_under_q;
        if (wr_sp) begin
            sp_d = reg_req_i.wdata[SAW-1:0];
            if (!reg_req_i.wdata[pcfu_pkg::BIT_STK_FULL]) begin
                stk_full_d = 1'b0;
            end
            if (!reg_req_i.wdata[pcfu_pkg::BIT_STK_UNDER]) begin
                stk_under_d = 1'b0;
            end
        end
        if (do_push && !stk_is_top) begin
            sp_d = sp_q + SAW'(1);
            if (sp_q == pcfu_pkg::STK_TOP - SAW'(1)) begin
                stk_full_d = 1'b1;
            end
        end else if (do_push) begin
            stk_full_d = 1'b1;
        end else if (do_ret && stk_is_0) begin
            stk_under_d = 1'b1;
        end else if (do_ret) begin
            sp_d = sp_q - SAW'(1);
        end
    end

    // Stack write: pre-incremented slot gets the current PC, which the
    // decoder has already stepped past the call. Full stack drops it.
    wire            stk_we    = do_push && !stk_is_top;
    wire [SAW-1:0]  stk_waddr = sp_q + SAW'(1);

    // ==========================================================
    // Read data mux
    // ==========================================================
    always_comb begin
        rdata_d = 8'h00;
        case (reg_req_i.addr)
            pcfu_pkg::OFS_PC_LOW:      rdata_d = pc_q[7:0];
            pcfu_pkg::OFS_HIGH_LATCH:  rdata_d = pc_high_latch_q;
            pcfu_pkg::OFS_UPPER_LATCH: rdata_d = {3'h0, pc_upper_latch_q};
            pcfu_pkg::OFS_TOS_LOW:     rdata_d = stack_top_word[7:0];
            pcfu_pkg::OFS_TOS_HIGH:    rdata_d = stack_top_word[15:8];
            pcfu_pkg::OFS_TOS_UPPER:   rdata_d = {3'h0,
                                                  stack_top_word[20:16]};
            pcfu_pkg::OFS_STACK_PTR:   rdata_d = {stk_full_q, stk_under_q,
                                                  1'b0, sp_q};
            pcfu_pkg::OFS_IRQ_CTRL:    rdata_d = {6'h00, gie_high_q,
                                                  gie_low_q};
            default:                   rdata_d = 8'h00;
        endcase
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Reset puts the PC on the reset vector for the first fetch.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pc_q <= pcfu_pkg::RESET_VEC;
        end else begin
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pc_high_latch_q  <= pcfu_pkg::LATCH_RST;
            pc_upper_latch_q <= pcfu_pkg::LATCH_RST[4:0];
            sp_q             <= pcfu_pkg::SP_RST;
            stk_full_q       <= 1'b0;
            stk_under_q      <= 1'b0;
        end else begin
            pc_high_latch_q  <= pc_high_latch_d;
            pc_upper_latch_q <= pc_upper_latch_d;
            sp_q             <= sp_d;
            stk_full_q       <= stk_full_d;
            stk_under_q      <= stk_under_d;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gie_low_q  <= 1'b0;
            gie_high_q <= 1'b0;
        end else if (wr_irqc) begin
            gie_low_q  <= reg_req_i.wdata[pcfu_pkg::BIT_GIE_LOW];
            gie_high_q <= reg_req_i.wdata[pcfu_pkg::BIT_GIE_HIGH];
        end
    end

    // Read data are valid only in the cycle after the strobe.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Fetch address mirrors the next PC so the port leaves a flop.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fetch_addr_o <= pcfu_pkg::RESET_VEC;
            sp_o         <= pcfu_pkg::SP_RST;
        end else begin
            fetch_addr_o <= pc_d;
            sp_o         <= sp_d;
        end
    end

    // ==========================================================
    // Memories
    // ==========================================================
    // Program memory has its own port, independent of the register
    // port, so a fetch never waits on a data access.
    pcfu_mem #(
        .WIDTH (pcfu_pkg::INSTR_W),
        .DEPTH (pcfu_pkg::PM_WORDS),
        .AW    (pcfu_pkg::PM_AW)
    ) u_prog_mem (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .we_i     (pm_we_i),
        .waddr_i  (pm_waddr_i),
        .wdata_i  (pm_wdata_i),
        .raddr_i  (pc_q[pcfu_pkg::PM_AW:1]),
        .zero_i   (pm_hole),
        .rdata_o  (fetch_data_o)
    );

    // Return stack: its registered read tracks the next pointer. A push
    // reads the slot it writes before the write lands, so a freshly
    // pushed word shows one cycle later; returns must be spaced.
    pcfu_mem #(
        .WIDTH (PC_W),
        .DEPTH (pcfu_pkg::STK_DEPTH),
        .AW    (SAW)
    ) u_ret_stack (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .we_i     (stk_we),
        .waddr_i  (stk_waddr),
        .wdata_i  (pc_q),
        .raddr_i  (sp_d),
        .zero_i   (sp_d == pcfu_pkg::SP_RST),
        .rdata_o  (stack_top_word)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_pcl_write;
        wr_pc_low && !take_irq;
    endsequence

    sequence s_irq_taken;
        take_irq;
    endsequence

    chk_pc_aligned: assert property (!pc_q[0] && !fetch_addr_o[0])
        else $error("PC bit zero is set");

    chk_seq_step: assert property (do_adv |=> pc_q == $past(pc_q) + 21'h2)
        else $error("Sequential step is not two");

    chk_pcl_write_load: assert property (s_pcl_write |=>
        pc_q == {$past(pc_upper_latch_q), $past(pc_high_latch_q),
                 $past(reg_req_i.wdata[7:1]), 1'b0})
        else $error("Low byte write did not load latches");

    chk_pcl_read_copy: assert property (rd_pc_low |=>
        pc_high_latch_q == $past(pc_q[15:8])
        && pc_upper_latch_q == $past(pc_q[20:16]))
        else $error("Low byte read did not fill latches");

    chk_pcl_read_data: assert property (rd_pc_low |=>
        reg_rdata_o == $past(pc_q[7:0]))
        else $error("Low byte read data wrong");

    chk_branch_direct: assert property (do_branch |=>
        pc_q == {$past(core_cmd_i.target[20:1]), 1'b0})
        else $error("Branch did not load its target");

    chk_irq_vector: assert property (s_irq_taken |=>
        pc_q == ($past(irq_high_i) ? 21'h000008 : 21'h000018))
        else $error("Interrupt vector not loaded");

    chk_irq_push: assert property ((s_irq_taken and !stk_is_top) |=>
        sp_q == $past(sp_q) + 5'h1 ##1 stack_top_word == $past(pc_q, 2))
        else $error("Interrupt did not push the PC");

    chk_hole_zero: assert property (pm_hole |=> fetch_data_o == 16'h0000)
        else $error("Unimplemented fetch not zero");

    chk_reset_start: assert property ($rose(arst_n_i) |-> pc_q == 21'h0)
        else $error("PC not at reset vector");

endmodule // pcfu_top

// File: testbench/pcfu_prog_model.sv
// Program store loader standing in for the on-chip program memory source.
`timescale 1ns/100ps

module pcfu_prog_model #(
    parameter int unsigned N_WORDS = 16
) (
    input  wire logic                         clk_i,      // Core clock.
    input  wire logic                         arst_n_i,   // Async reset, low.
    output logic                              pm_we_o,    // Load strobe.
    output logic [pcfu_pkg::PM_AW-1:0]        pm_waddr_o, // Word index.
    output logic [pcfu_pkg::INSTR_W-1:0]      pm_wdata_o, // Program word.
    output logic                              done_o      // All loaded.
);
    // ==========================================================
    // Load sequence
    // ==========================================================
    logic [pcfu_pkg::PM_AW-1:0] idx_q;

    // Each word carries its own index, so a wrong fetch index shows.
    assign done_o     = (idx_q == pcfu_pkg::PM_AW'(N_WORDS));
    assign pm_we_o    = !done_o;
    assign pm_waddr_o = idx_q;
    assign pm_wdata_o = {3'h6, idx_q};

    // One word per cycle after reset, then stop for good.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_q <= '0;
        end else if (!done_o) begin
            idx_q <= idx_q + 1'b1;
        end
    end
endmodule // pcfu_prog_model

// File: testbench/pcfu_top_tb.sv
// Self-checking bench for the program counter fetch unit.
`timescale 1ns/100ps

module pcfu_top_tb;
    logic                     clk_i    = 1'b0;
    logic                     arst_n_i = 1'b0;
    pcfu_pkg::pcfu_reg_req_t  req      = '0;
    pcfu_pkg::pcfu_core_cmd_t cmd      = '0;
    logic                     wake     = 1'b0;
    logic                     high     = 1'b0;
    logic                     pm_we;
    logic [12:0]              pm_waddr;
    logic [15:0]              pm_wdata;
    logic                     loaded;
    logic [7:0]               rdata;
    logic [20:0]              pc;
    logic [15:0]              fdata;
    logic [4:0]               sp;
    logic [7:0]               rd_q;
    int                       err_count = 0;
    int                       checked   = 0;
    int                       cycles    = 0;

    always #12.5 clk_i = ~clk_i;

    pcfu_top u_pcfu_top (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .core_cmd_i(cmd), .irq_wake_i(wake),
        .irq_high_i(high), .pm_we_i(pm_we), .pm_waddr_i(pm_waddr),
        .pm_wdata_i(pm_wdata), .fetch_addr_o(pc), .fetch_data_o(fdata),
        .sp_o(sp)
    );
    pcfu_prog_model u_pcfu_prog_model (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .pm_we_o(pm_we),
        .pm_waddr_o(pm_waddr), .pm_wdata_o(pm_wdata), .done_o(loaded)
    );

    // ==========================================================
    // Tasks
    // ==========================================================
    function automatic logic [15:0] word(input int i);
        return {3'h6, 13'(i)};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Requests go out at a rising edge and are taken at the next one;
    // read data is captured in the one cycle it stands, and outputs
    // settle by the end.
    task automatic op(input logic [12:0] r, input logic [24:0] c,
                      input logic w);
        @(posedge clk_i);
        req  <= r;
        cmd  <= c;
        wake <= w;
        @(posedge clk_i);
        req  <= '0;
        cmd  <= '0;
        wake <= 1'b0;
        #1 rd_q = rdata;
        @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        op({2'b10, a, d}, '0, 1'b0);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        op({2'b01, a, 8'h00}, '0, 1'b0);
        check(rd_q, exp);
    endtask

    task automatic core(input logic [3:0] f, input logic [20:0] t);
        op('0, {f, t}, 1'b0);
    endtask

    task automatic irq(input logic h);
        @(posedge clk_i);
        high <= h;
        op('0, '0, 1'b1);
    endtask

    task automatic set_pc(input logic [7:0] hi, up, lo);
        wr(3'h1, hi);
        wr(3'h2, up);
        wr(3'h0, lo);
    endtask

    // A hang is cut short and counted as a mismatch.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            test_done();
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (4) @(posedge clk_i);
        check(pc, 32'h0);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 50 && loaded !== 1'b1; i++) @(posedge clk_i);
        #1 check(sp, 32'h0);
        $display("reset test done");
        for (int i = 1; i <= 3; i++) begin
            core(4'h8, 21'h0);
            check(pc, 2 * i);
            check(fdata, word(i));
        end
        $display("sequential test done");
        set_pc(8'h12, 8'hff, 8'h35);
        check(pc, 32'h1f1234);
        check(fdata, 32'h0);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h00);
        rd(3'h0, 8'h34);
        rd(3'h1, 8'h12);
        rd(3'h2, 8'h1f);
        set_pc(8'h40, 8'h00, 8'h00);
        check(fdata, 32'h0);
        set_pc(8'h00, 8'h00, 8'h00);
        check(fdata, word(0));
        $display("latch test done");
        wr(3'h1, 8'h55);
        wr(3'h2, 8'h03);
        core(4'h4, 21'h000100);
        check(pc, 32'h100);
        core(4'h6, 21'h000200);
        check(pc, 32'h200);
        check(sp, 32'h1);
        rd(3'h3, 8'h00);
        rd(3'h4, 8'h01);
        rd(3'h1, 8'h55);
        $display("branch test done");
        irq(1'b1);
        check(pc, 32'h200);
        wr(3'h7, 8'h01);
        irq(1'b1);
        check(pc, 32'h8);
        check(sp, 32'h2);
        rd(3'h4, 8'h02);
        wr(3'h7, 8'h02);
        irq(1'b0);
        check(pc, 32'h18);
        check(sp, 32'h3);
        rd(3'h3, 8'h08);
        $display("interrupt test done");
        op({2'b01, 3'h6, 8'h00}, {4'h8, 21'h0}, 1'b0);
        check(rd_q, 8'h03);
        check(pc, 32'h1a);
        check(fdata, word(13));
        $display("concurrency test done");
        core(4'h1, 21'h0);
        check(pc, 32'h8);
        check(sp, 32'h2);
        core(4'h1, 21'h0);
        check(pc, 32'h200);
        check(sp, 32'h1);
        core(4'h1, 21'h0);
        check(pc, 32'h100);
        check(sp, 32'h0);
        core(4'h1, 21'h0);
        check(pc, 32'h0);
        rd(3'h6, 8'h40);
        wr(3'h6, 8'h00);
        rd(3'h6, 8'h00);
        $display("return test done");
        for (int i = 0; i < 31; i++) core(4'h6, 21'h000040);
        check(sp, 32'h1f);
        rd(3'h6, 8'h9f);
        op({2'b10, 3'h6, 8'h00}, {4'h6, 21'h000040}, 1'b0);
        check(sp, 32'h0);
        rd(3'h6, 8'h80);
        $display("stack full test done");
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        #1 check(pc, 32'h0);
        check(sp, 32'h0);
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        core(4'h8, 21'h0);
        check(pc, 32'h2);
        $display("second reset test done");
        test_done();
    end
endmodule // pcfu_top_tb
